// [core/cpu_bus_if.sv]
`timescale 1ns/1ns
// Function
// [RL1] fourteen tri-state address lines, msb first
// [RL2] memory address on bus during memory cycle
// [RL3] io bit address when memory enable off
// [RL4] hold acknowledge floats all address lines
// [RL5] serial out bit on address lsb
// [RL6] io logic samples bit on strobe high
// [RL7] external instruction code bit on lsb
// [RL8] eight bidirectional tri-state data lines
// [RL9] data bus carries memory read/write data
// [RL10] hold acknowledge floats all data lines
// [RL11] mode one: crystal oscillator amplifier
// [RL12] mode two: external ttl clock source
// [RL13] output inverted clock phase three
// [RL14] memory read: direction high, outputs off
// [RL15] direction low otherwise, floats on hold
// [RL16] hold after current plus next memory cycle
// [RL17] ready low inserts wait states
// [RL18] memory enable low with memory address
// [RL19] strobe pulses high for io sampling
// [RL20] input clock divided by four phases
// [RL21] serial bit stable during strobe pulse
module cpu_bus_if (
  // clock and reset
  input  wire logic                               ref_clk,
  input  wire logic                               rstn,
  // core side request
  input  wire logic                               req_valid,
  input  wire bus_if_pkg::req_type                req,
  output logic                                    req_ready,
  output logic                                    done,
  output logic [0:bus_if_pkg::DATA_W-1]           rdata,
  // address bus and memory control
  output logic [0:bus_if_pkg::ADDR_W-1]           addr_out,
  output logic                                    addr_oe,
  output logic                                    memory_cycle_enable_n,
  output logic                                    memory_cycle_enable_oe,
  output logic                                    read_direction,
  output logic                                    read_direction_oe,
  input  wire logic                               ready,
  // data bus
  input  wire logic [0:bus_if_pkg::DATA_W-1]      data_in,
  output logic [0:bus_if_pkg::DATA_W-1]           data_out,
  output logic                                    data_oe,
  // serial io
  output logic                                    serial_io_strobe,
  // bus release
  input  wire logic                               hold_n,
  output logic                                    bus_release_ack,
  // clocks
  input  wire logic                               clock_mode,
  input  wire logic                               osc_input,
  output logic                                    osc_output,
  output logic                                    osc_output_oe,
  output logic                                    phase3_n
);

  // ----------------------------------------------------------------
  // decode helpers
  // ----------------------------------------------------------------
  function automatic logic is_mem(input bus_if_pkg::kind_type k);
    is_mem = (k == bus_if_pkg::KIND_MEM_RD) || (k == bus_if_pkg::KIND_MEM_WR);
  endfunction : is_mem

  // ----------------------------------------------------------------
  // phase divider
  // ----------------------------------------------------------------
  logic [1:0]              phase_q;
  logic [1:0]              phase_d;
  logic                    sys_tick;
  logic                    phase3_n_q;
  logic                    osc_q;

  assign phase_d  = phase_q + 2'h1; // RL20
  assign sys_tick = (phase_q == bus_if_pkg::LAST_PH);

  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      phase_q    <= bus_if_pkg::PH_RESET;
      phase3_n_q <= 1'h1;
      osc_q      <= 1'h0;
    end else begin
      phase_q    <= phase_d;
      phase3_n_q <= (phase_d != bus_if_pkg::PH3_IDX); // RL13
      osc_q      <= ~osc_input; // RL11
    end
  end

  // the amplifier is only driven with a crystal; a ttl source leaves it open
  assign osc_output    = osc_q;
  assign osc_output_oe = (clock_mode == bus_if_pkg::MODE_XTAL); // RL11 RL12
  assign phase3_n      = phase3_n_q;

  // ----------------------------------------------------------------
  // cycle sequencer
  // ----------------------------------------------------------------
  bus_if_pkg::state_type   state_q;
  bus_if_pkg::state_type   state_d;
  bus_if_pkg::req_type     cur_q;
  logic                    follow_q;
  logic [0:bus_if_pkg::DATA_W-1] rdata_q;
  logic                    done_q;
  logic                    hold_req;
  logic                    mem_end;
  logic                    follow_ok;
  logic                    take;

  assign hold_req  = ~hold_n;
  assign mem_end   = (state_q == bus_if_pkg::ST_MEM) && sys_tick && ready; // RL17
  // under hold, only one more memory cycle may start right after the current one
  assign follow_ok = !follow_q && is_mem(req.kind); // RL16
  assign take      = req_valid && sys_tick &&
                     (((state_q == bus_if_pkg::ST_IDLE) && !hold_req) ||
                      (mem_end && (!hold_req || follow_ok)));
  assign req_ready = sys_tick &&
                     (((state_q == bus_if_pkg::ST_IDLE) && !hold_req) ||
                      (mem_end && (!hold_req || follow_ok)));

  always_comb begin
    state_d = state_q;
    case (state_q)
      bus_if_pkg::ST_IDLE: begin
        if (sys_tick && hold_req) begin
          state_d = bus_if_pkg::ST_HOLD;
        end else if (take) begin
          state_d = is_mem(req.kind) ? bus_if_pkg::ST_MEM : bus_if_pkg::ST_IO_SETUP;
        end
      end
      bus_if_pkg::ST_MEM: begin
        if (take) begin
          state_d = is_mem(req.kind) ? bus_if_pkg::ST_MEM : bus_if_pkg::ST_IO_SETUP;
        end else if (mem_end) begin
          state_d = hold_req ? bus_if_pkg::ST_HOLD : bus_if_pkg::ST_IDLE; // RL16
        end
      end
      bus_if_pkg::ST_IO_SETUP: begin
        if (sys_tick) begin
          state_d = bus_if_pkg::ST_IO_STROBE;
        end
      end
      bus_if_pkg::ST_IO_STROBE: begin
        if (sys_tick) begin
          state_d = hold_req ? bus_if_pkg::ST_HOLD : bus_if_pkg::ST_IDLE;
        end
      end
      bus_if_pkg::ST_HOLD: begin
        if (sys_tick && !hold_req) begin
          state_d = bus_if_pkg::ST_IDLE;
        end
      end
      default: begin
        state_d = bus_if_pkg::ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      state_q  <= bus_if_pkg::ST_IDLE;
      cur_q    <= bus_if_pkg::REQ_RESET;
      follow_q <= 1'h0;
      rdata_q  <= 8'h00;
      done_q   <= 1'h0;
    end else begin
      state_q <= state_d;
      done_q  <= mem_end || ((state_q == bus_if_pkg::ST_IO_STROBE) && sys_tick);
      if (take) begin
        cur_q <= req;
      end
      // a dropped hold request ends the follow-on allowance, so a later hold gets its own
      if ((state_q == bus_if_pkg::ST_HOLD) || !hold_req) begin
        follow_q <= 1'h0;
      end else if (take && (state_q == bus_if_pkg::ST_MEM) && hold_req) begin
        follow_q <= 1'h1;
      end
      if (mem_end && (cur_q.kind == bus_if_pkg::KIND_MEM_RD)) begin
        rdata_q <= data_in; // RL9
      end
    end
  end

  assign done  = done_q;
  assign rdata = rdata_q;

  // ----------------------------------------------------------------
  // pin drive
  // ----------------------------------------------------------------
  logic                    in_mem;
  logic                    in_io;
  logic                    in_hold;
  logic                    mem_rd;

  assign in_mem  = (state_q == bus_if_pkg::ST_MEM);
  assign in_io   = (state_q == bus_if_pkg::ST_IO_SETUP) || (state_q == bus_if_pkg::ST_IO_STROBE);
  assign in_hold = (state_q == bus_if_pkg::ST_HOLD);
  assign mem_rd  = in_mem && (cur_q.kind == bus_if_pkg::KIND_MEM_RD);

  // address lsb carries the serial bit or external code bit in io cycles;
  // cur_q only changes at a cycle boundary, so the bit holds through the strobe
  assign addr_out = in_io ? {cur_q.addr[0:bus_if_pkg::ADDR_W-2], cur_q.io_bit} // RL3 RL5 RL7 RL21
                          : cur_q.addr; // RL1 RL2
  assign addr_oe  = !in_hold; // RL4

  assign memory_cycle_enable_n  = !in_mem; // RL18
  assign memory_cycle_enable_oe = !in_hold;
  assign read_direction         = mem_rd; // RL14 RL15
  assign read_direction_oe      = !in_hold; // RL15
  assign data_out               = cur_q.wdata;
  assign data_oe                = in_mem && (cur_q.kind == bus_if_pkg::KIND_MEM_WR); // RL8 RL9 RL10
  assign serial_io_strobe       = (state_q == bus_if_pkg::ST_IO_STROBE); // RL19
  assign bus_release_ack        = in_hold;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  hold_float_a: assert property (@(posedge ref_clk) disable iff (!rstn) // RL4
    bus_release_ack |-> !addr_oe && !data_oe && !memory_cycle_enable_oe)
    else $error("buses driven during hold");

  data_float_a: assert property (@(posedge ref_clk) disable iff (!rstn) // RL10
    data_oe |-> !bus_release_ack && !memory_cycle_enable_n && !read_direction)
    else $error("data driven outside a write cycle");

  read_dir_a: assert property (@(posedge ref_clk) disable iff (!rstn) // RL14
    read_direction |-> !data_oe && !memory_cycle_enable_n)
    else $error("read direction without memory read");

  dir_low_a: assert property (@(posedge ref_clk) disable iff (!rstn) // RL15
    memory_cycle_enable_n |-> !read_direction && (read_direction_oe == !bus_release_ack))
    else $error("read direction not low outside memory");

  io_addr_a: assert property (@(posedge ref_clk) disable iff (!rstn) // RL3
    serial_io_strobe |-> memory_cycle_enable_n && addr_oe && (addr_out[bus_if_pkg::ADDR_W-1] == cur_q.io_bit))
    else $error("io address wrong during strobe");

  strobe_len_a: assert property (@(posedge ref_clk) disable iff (!rstn) // RL19
    $rose(serial_io_strobe) |-> serial_io_strobe[*4] ##1 !serial_io_strobe)
    else $error("strobe not four cycles");

  strobe_bit_a: assert property (@(posedge ref_clk) disable iff (!rstn) // RL21
    serial_io_strobe && $past(serial_io_strobe) |-> $stable(addr_out))
    else $error("address moved during strobe");

  phase_div_a: assert property (@(posedge ref_clk) disable iff (!rstn) // RL20
    sys_tick |=> !sys_tick [*3] ##1 sys_tick)
    else $error("system tick not every fourth cycle");

  phase3_a: assert property (@(posedge ref_clk) disable iff (!rstn) // RL13
    $fell(phase3_n) |=> $rose(phase3_n) ##3 $fell(phase3_n))
    else $error("phase three output period wrong");

  wait_state_a: assert property (@(posedge ref_clk) disable iff (!rstn) // RL17
    in_mem && sys_tick && !ready |=> in_mem && !done)
    else $error("memory cycle ended while not ready");

  hold_entry_a: assert property (@(posedge ref_clk) disable iff (!rstn) // RL16
    mem_end && hold_req && !take |=> bus_release_ack)
    else $error("hold not entered after memory cycle");

  osc_mode_a: assert property (@(posedge ref_clk) disable iff (!rstn) // RL11
    (clock_mode == bus_if_pkg::MODE_TTL) |-> !osc_output_oe)
    else $error("oscillator driven in ttl mode");

  // bus pins move only on a system-tick edge, so slow memory sees a whole system clock of setup
  link_stable_a: assert property (@(posedge ref_clk) disable iff (!rstn) // RL2
    !sys_tick |=> $stable(addr_out) && $stable(memory_cycle_enable_n) && $stable(read_direction))
    else $error("bus pins moved between system ticks");

  // under hold, at most one memory cycle may follow the one in progress
  follow_once_a: assert property (@(posedge ref_clk) disable iff (!rstn) // RL16
    follow_q && hold_req |-> !take)
    else $error("second follow-on cycle taken under hold");

  idle_hold_a: assert property (@(posedge ref_clk) disable iff (!rstn) // RL16
    (state_q == bus_if_pkg::ST_IDLE) && sys_tick && hold_req |=> bus_release_ack)
    else $error("hold not entered from idle");

  hold_exit_a: assert property (@(posedge ref_clk) disable iff (!rstn) // RL16
    bus_release_ack && sys_tick && !hold_req |=> !bus_release_ack && addr_oe)
    else $error("hold not left after request removed");

  hold_dir_a: assert property (@(posedge ref_clk) disable iff (!rstn) // RL15
    bus_release_ack |-> !read_direction_oe && !read_direction)
    else $error("read direction driven during hold");

  strobe_quiet_a: assert property (@(posedge ref_clk) disable iff (!rstn) // RL19
    serial_io_strobe |-> !data_oe && !read_direction && !bus_release_ack)
    else $error("memory signals active during strobe");

  // a memory cycle lasts at least one system clock, so completions never touch
  done_pulse_a: assert property (@(posedge ref_clk) disable iff (!rstn) // RL9
    done |=> !done)
    else $error("completion longer than one cycle");

  // the timing output must line up with the divider, not only have the right period
  phase3_pos_a: assert property (@(posedge ref_clk) disable iff (!rstn) // RL13
    !phase3_n |-> (phase_q == bus_if_pkg::PH3_IDX))
    else $error("phase three output off its phase");

endmodule : cpu_bus_if

// [core/bus_if_pkg.sv]
package bus_if_pkg;
  // ----------------------------------------------------------------
  // widths and timing
  // ----------------------------------------------------------------
  localparam int ADDR_W     = 14;
  localparam int DATA_W     = 8;
  localparam int CLK_DIV    = 4;
  localparam logic [1:0] PH3_IDX  = 2'h2;
  localparam logic [1:0] LAST_PH  = 2'h3;
  localparam logic [1:0] PH_RESET = 2'h0;
  localparam logic       MODE_XTAL = 1'h0;
  localparam logic       MODE_TTL  = 1'h1;

  // ----------------------------------------------------------------
  // types
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    KIND_MEM_RD  = 2'h0,
    KIND_MEM_WR  = 2'h1,
    KIND_SER_OUT = 2'h2,
    KIND_EXT     = 2'h3
  } kind_type;

  typedef enum logic [2:0] {
    ST_IDLE      = 3'h0,
    ST_MEM       = 3'h1,
    ST_IO_SETUP  = 3'h2,
    ST_IO_STROBE = 3'h3,
    ST_HOLD      = 3'h4
  } state_type;

  typedef struct packed {
    kind_type          kind;
    logic [0:ADDR_W-1] addr;
    logic [0:DATA_W-1] wdata;
    logic              io_bit;
  } req_type;

  localparam req_type REQ_RESET = '{kind: KIND_MEM_RD, addr: 14'h0000, wdata: 8'h00, io_bit: 1'h0};
endpackage : bus_if_pkg

// [dv/mem_partner.sv]
`timescale 1ns/1ns
module mem_partner (
  // clock
  input  wire logic                               ref_clk,
  // device pins
  input  wire logic [0:bus_if_pkg::ADDR_W-1]      addr_out,
  input  wire logic                               memory_cycle_enable_n,
  input  wire logic                               read_direction,
  input  wire logic [0:bus_if_pkg::DATA_W-1]      data_out,
  input  wire logic                               data_oe,
  input  wire logic                               serial_io_strobe,
  output logic                                    ready,
  output logic [0:bus_if_pkg::DATA_W-1]           data_in,
  // bench view
  input  wire logic [3:0]                         wait_cycles,
  output logic [0:bus_if_pkg::DATA_W-1]           wr_seen,
  output logic                                    ser_seen
);
  logic [3:0] cnt_q = 4'h0;
  logic [0:7] last_q = 8'h00;
  wire        rd_sel = read_direction && !memory_cycle_enable_n;

  // slow memory: ready only after the requested number of clocks
  always @(posedge ref_clk) cnt_q <= memory_cycle_enable_n ? 4'h0 : (cnt_q == 4'hF ? cnt_q : cnt_q + 4'h1);
  assign ready = !memory_cycle_enable_n && (cnt_q >= wait_cycles);
  // a released bus shows the inverse, never a stale copy of the last value
  assign data_in = rd_sel ? (addr_out[6:13] ^ 8'h5A) : ~last_q;
  always @(posedge ref_clk) if (rd_sel) last_q <= addr_out[6:13] ^ 8'h5A;
  always @(posedge ref_clk) if (!memory_cycle_enable_n && data_oe && ready) wr_seen <= data_out;
  always @(posedge serial_io_strobe) ser_seen <= addr_out[13];
endmodule : mem_partner

// [dv/test_cpu_external_bus_interface.sv]
`timescale 1ns/1ns
module test_cpu_external_bus_interface;
  logic ref_clk = 1'b0, rstn = 1'b0, req_valid = 1'b0, hold_n = 1'b1, clock_mode = 1'b0, osc_input = 1'b0;
  bus_if_pkg::req_type req = bus_if_pkg::REQ_RESET;
  logic [3:0] wait_cycles = 4'h0;
  logic req_ready, done, addr_oe, mce_n, mce_oe, read_direction, rd_oe, ready, data_oe;
  logic serial_io_strobe, bus_release_ack, osc_output, osc_output_oe, phase3_n, ser_seen;
  logic [0:7] rdata, data_in, data_out, wr_seen;
  logic [0:13] addr_out;
  int fail_count = 0, checks = 0;
  logic [9:0] note_q[$];
  logic [9:0] note;
  always #20 ref_clk = ~ref_clk;

  cpu_bus_if i_cpu_bus_if (.ref_clk(ref_clk), .rstn(rstn), .req_valid(req_valid), .req(req),
    .req_ready(req_ready), .done(done), .rdata(rdata), .addr_out(addr_out), .addr_oe(addr_oe),
    .memory_cycle_enable_n(mce_n), .memory_cycle_enable_oe(mce_oe), .read_direction(read_direction),
    .read_direction_oe(rd_oe), .ready(ready), .data_in(data_in), .data_out(data_out), .data_oe(data_oe),
    .serial_io_strobe(serial_io_strobe), .hold_n(hold_n), .bus_release_ack(bus_release_ack),
    .clock_mode(clock_mode), .osc_input(osc_input), .osc_output(osc_output),
    .osc_output_oe(osc_output_oe), .phase3_n(phase3_n));
  mem_partner i_mem_partner (.ref_clk(ref_clk), .addr_out(addr_out), .memory_cycle_enable_n(mce_n),
    .read_direction(read_direction), .data_out(data_out), .data_oe(data_oe),
    .serial_io_strobe(serial_io_strobe), .ready(ready), .data_in(data_in), .wait_cycles(wait_cycles),
    .wr_seen(wr_seen), .ser_seen(ser_seen));

  task automatic chk(input string name, input logic [7:0] exp, input logic [7:0] got);
    checks++;
    if (got !== exp) begin
      fail_count++;
      $display("MISMATCH %s expected %h seen %h", name, exp, got);
    end
  endtask : chk

  task automatic wrap_up;
    $display("checks %0d mismatches %0d", checks, fail_count);
    if (fail_count == 0 && checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : wrap_up

  // ----------------------------------------------------------------
  // request driver: request held until the taking edge
  // ----------------------------------------------------------------
  task automatic issue(input bus_if_pkg::kind_type k, input logic [0:13] a, input logic [0:7] w, input logic b);
    int n;
    @(posedge ref_clk);
    req_valid <= 1'b1;
    req <= '{kind: k, addr: a, wdata: w, io_bit: b};
    if (k == bus_if_pkg::KIND_MEM_RD) note_q.push_back({2'h0, a[6:13] ^ 8'h5A});
    else if (k == bus_if_pkg::KIND_MEM_WR) note_q.push_back({2'h1, w});
    else note_q.push_back({2'h2, 7'h00, b});
    n = 0;
    do begin
      @(negedge ref_clk);
      n++;
    end while (req_ready !== 1'b1 && n < 200);
    if (req_ready !== 1'b1) fail_count++;
    @(posedge ref_clk);
    req_valid <= 1'b0;
    n = 0;
    while (done !== 1'b1 && n < 200) begin
      @(negedge ref_clk);
      n++;
    end
    if (done !== 1'b1) fail_count++;
    @(negedge ref_clk);
  endtask : issue

  // ----------------------------------------------------------------
  // result monitor: oldest note against each completion
  // ----------------------------------------------------------------
  // sampled mid-cycle, away from the edge that launches done and its data
  always @(negedge ref_clk) if (done === 1'b1) begin
    note = note_q.pop_front();
    if (note[9:8] == 2'h0) chk("rdata", note[7:0], rdata);
    else if (note[9:8] == 2'h1) chk("write data", note[7:0], wr_seen);
    else chk("serial bit", note[7:0], {7'h00, ser_seen});
  end

  initial begin
    #400000;
    fail_count++;
    wrap_up();
  end

  initial begin
    int lows;
    logic prev;
    void'($urandom(47006));
    repeat (16) @(posedge ref_clk);
    rstn <= 1'b1;
    for (int i = 0; i < 24; i++) begin
      wait_cycles <= 4'($urandom_range(0, 9));
      issue(bus_if_pkg::kind_type'(i % 4), 14'($urandom), 8'($urandom), 1'($urandom));
    end
    // hold during a read: that read, one following read, then release
    wait_cycles <= 4'h9;
    @(posedge ref_clk);
    req_valid <= 1'b1;
    req <= '{kind: bus_if_pkg::KIND_MEM_RD, addr: 14'h2A5C, wdata: 8'h00, io_bit: 1'b0};
    note_q.push_back({2'h0, 8'h06});
    note_q.push_back({2'h0, 8'h06});
    do @(negedge ref_clk); while (req_ready !== 1'b1);
    @(posedge ref_clk);
    hold_n <= 1'b0;
    repeat (24) @(negedge ref_clk);
    chk("follow ack", 8'h01, {7'h00, bus_release_ack});
    chk("follow reads", 8'h00, 8'(note_q.size()));
    @(posedge ref_clk);
    req_valid <= 1'b0;
    hold_n <= 1'b1;
    repeat (8) @(negedge ref_clk);
    // bus release: every bus driver floats
    @(posedge ref_clk);
    hold_n <= 1'b0;
    repeat (12) @(negedge ref_clk);
    chk("release ack", 8'h01, {7'h00, bus_release_ack});
    chk("floats", 8'h00, {4'h0, addr_oe, data_oe, rd_oe, mce_oe});
    @(posedge ref_clk);
    hold_n <= 1'b1;
    repeat (12) @(negedge ref_clk);
    chk("drives", 8'h0B, {4'h0, addr_oe, data_oe, rd_oe, mce_oe});
    issue(bus_if_pkg::KIND_MEM_RD, 14'h3FFF, 8'h00, 1'b0);
    // timing reference and oscillator in both clock modes
    for (int m = 0; m < 2; m++) begin
      @(posedge ref_clk);
      clock_mode <= 1'(m);
      lows = 0;
      prev = osc_input;
      repeat (16) begin
        @(posedge ref_clk);
        osc_input <= 1'($urandom);
        @(negedge ref_clk);
        lows += (phase3_n === 1'b0);
        chk("osc_output", {7'h00, ~prev}, {7'h00, osc_output});
        prev = osc_input;
      end
      chk("phase3 lows", 8'h04, 8'(lows));
      chk("osc_output_oe", {7'h00, ~1'(m)}, {7'h00, osc_output_oe});
    end
    chk("notes left", 8'h00, 8'(note_q.size()));
    wrap_up();
  end
endmodule : test_cpu_external_bus_interface
